// file: hw/rcss_pkg.sv
// constants and types of the reset configuration source selector
package rcss_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SAFE_WORD = 8'h08;
  localparam logic [7:0] OFF_FORCE_WORD = 8'h0c;
  localparam logic [7:0] OFF_READ_COUNT = 8'h10;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_CLR_COUNT_BIT = 1;
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_WIDTH_BAD_BIT = 7;
  localparam int STAT_SW_LSB = 8;
  localparam int STAT_MODE_LO_LSB = 16;
  localparam int STAT_MODE_HI_LSB = 20;
  localparam int STAT_BLANK_BIT = 24;
  localparam int SW_MODE_LO_LSB = 0;
  localparam int SW_MODE_HI_LSB = 3;
  localparam int SW_FLASH_EN_BIT = 6;
  localparam int SW_HOST_OFF_BIT = 7;
  localparam int HI_FIELD_LSB = 0;

  // ----------------------------------------------------------------------
  // widths, counts and reset values
  // ----------------------------------------------------------------------
  localparam int SW_W = 8;
  localparam int MODE_W = 3;
  localparam int WORD_W = 32;
  localparam int CFG_WORDS = 8;
  localparam int IDX_W = 3;
  localparam int CNT_W = 4;
  localparam logic [31:0] SAFE_WORD_RST = 32'h0000_0000;
  localparam logic [31:0] FORCE_WORD_RST = 32'h0000_0000;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // ----------------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    RCSS_SRC_SAFE = 4'b0001,
    RCSS_SRC_FLASH = 4'b0010,
    RCSS_SRC_HOST = 4'b0100,
    RCSS_SRC_FORCE = 4'b1000
  } rcss_src_e;

  typedef enum logic [2:0] {
    RCSS_ST_POR = 3'b001,
    RCSS_ST_RUN = 3'b010,
    RCSS_ST_SERVE = 3'b100
  } rcss_state_e;

endpackage

// file: hw/rcss_if.sv
// internal links between the selector and its strap and word blocks
`timescale 1ns/1ps
interface rcss_if;
  logic [rcss_pkg::MODE_W-1:0] mode_lo;
  logic [rcss_pkg::MODE_W-1:0] mode_hi;
  logic mode_oe;
  logic word_en;
  logic insert_hi;
  logic [rcss_pkg::IDX_W:0] word_idx;
  logic [rcss_pkg::WORD_W-1:0] word_base;

  modport strap (output mode_lo, output mode_hi, output mode_oe);
  modport word (input mode_hi, input word_en, input insert_hi,
                input word_idx, input word_base);
  modport main (input mode_lo, input mode_hi, input mode_oe,
                output word_en, output insert_hi, output word_idx,
                output word_base);
endinterface

// file: hw/rcss_strap.sv
// power-on capture and drive of the pll mode lines
`timescale 1ns/1ps
module rcss_strap (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic por_n_in,
  input wire logic [rcss_pkg::SW_W-1:0] sw_in,
  rcss_if.strap lnk
);

  // ----------------------------------------------------------------------
  // mode lines follow switches only during power-on reset
  // ----------------------------------------------------------------------
  // drive low mode
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      lnk.mode_lo <= '0;
      lnk.mode_oe <= 1'b0;
    end else if (!por_n_in) begin
      lnk.mode_lo <= sw_in[rcss_pkg::SW_MODE_LO_LSB +: rcss_pkg::MODE_W];
      lnk.mode_oe <= 1'b1;
    end else begin
      lnk.mode_oe <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      lnk.mode_hi <= '0;
    end else if (!por_n_in) begin
      lnk.mode_hi <= sw_in[rcss_pkg::SW_MODE_HI_LSB +: rcss_pkg::MODE_W];
    end
  end

endmodule

// file: hw/rcss_word.sv
// configuration word driver onto the processor data bus
`timescale 1ns/1ps
module rcss_word (
  input wire logic clk_in,
  input wire logic nrst_in,
  rcss_if.word lnk,
  output logic [rcss_pkg::WORD_W-1:0] data_out,
  output logic data_oe_out
);

  // ----------------------------------------------------------------------
  // word shaping
  // ----------------------------------------------------------------------
  function automatic logic [rcss_pkg::WORD_W-1:0] shape(
    input logic [rcss_pkg::WORD_W-1:0] base,
    input logic [rcss_pkg::MODE_W-1:0] hi,
    input logic ins,
    input logic [rcss_pkg::IDX_W:0] idx
  );
    logic [rcss_pkg::WORD_W-1:0] w;
    w = base;
    if (ins) begin
      w[rcss_pkg::HI_FIELD_LSB +: rcss_pkg::MODE_W] = hi;
    end
    if (idx != '0) begin
      w = '0;
    end
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // registered bus drive
  // ----------------------------------------------------------------------
  // drive only on reads
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      data_oe_out <= 1'b0;
      data_out <= '0;
    end else if (lnk.word_en) begin
      data_oe_out <= 1'b1;
      data_out <= shape(lnk.word_base, lnk.mode_hi, lnk.insert_hi,
                        lnk.word_idx);
    end else begin
      data_oe_out <= 1'b0;
      data_out <= '0;
    end
  end

endmodule

// file: hw/rcss_top.sv
// reset configuration source selector with apb control registers
//
// Overview of operation
// - during power-on reset drive low pll mode lines from switches 1-3
// - safe source (flash enable off or flash blank): board supplies high mode field from switches 4-6
// - present configuration word on reads while hard reset is asserted, for safe and force sources only
// - flash enable switch off gives safe mode, on gives flash unless the flash is blank
// - configuration switch off selects host, overriding flash enable
// - eight words are read; only the first carries meaning
// - mode lines sampled at power-up only, never on later resets
// - control register can force the configuration word
`timescale 1ns/1ps
module rcss_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic por_n_in,
  input wire logic hard_reset_n_in,
  input wire logic [rcss_pkg::SW_W-1:0] config_dip_switch_in,
  input wire logic flash_blank_in,
  input wire logic bus_narrow_in,
  input wire logic cfg_rd_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [rcss_pkg::MODE_W-1:0] pll_mode_lines_out,
  output logic pll_mode_oe_out,
  output logic [3:0] cfg_src_out,
  output logic [rcss_pkg::WORD_W-1:0] data_out,
  output logic data_oe_out
);

  // ----------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------
  generate
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
      $error("address width cannot hold the register map");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  rcss_if lnk ();
  rcss_pkg::rcss_state_e state;
  rcss_pkg::rcss_state_e next_state;
  rcss_pkg::rcss_src_e src;
  rcss_pkg::rcss_src_e next_src;
  logic force_en;
  logic [31:0] safe_word;
  logic [31:0] force_word;
  logic [rcss_pkg::CNT_W-1:0] rd_count;
  logic [rcss_pkg::IDX_W:0] idx_hold;
  logic [rcss_pkg::IDX_W:0] read_idx;
  logic rd_q;
  logic rd_rise;
  logic board_src;
  logic entering_serve;
  logic apb_setup;
  logic apb_wr;
  logic apb_rd;
  logic [7:0] addr8;
  logic addr_hit;
  logic clr_count;
  logic [31:0] status_word;

  // ----------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------
  rcss_strap u_strap (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .por_n_in(por_n_in),
    .sw_in(config_dip_switch_in),
    .lnk(lnk)
  );

  rcss_word u_word (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .lnk(lnk),
    .data_out(data_out),
    .data_oe_out(data_oe_out)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic rcss_pkg::rcss_src_e pick_src(
    input logic [rcss_pkg::SW_W-1:0] sw,
    input logic frc,
    input logic blank
  );
    rcss_pkg::rcss_src_e s;
    if (frc) begin
      s = rcss_pkg::RCSS_SRC_FORCE;
    end else if (!sw[rcss_pkg::SW_HOST_OFF_BIT]) begin
      s = rcss_pkg::RCSS_SRC_HOST;
    end else if (!sw[rcss_pkg::SW_FLASH_EN_BIT] || blank) begin
      s = rcss_pkg::RCSS_SRC_SAFE;
    end else begin
      s = rcss_pkg::RCSS_SRC_FLASH;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // reset phase tracking
  // ----------------------------------------------------------------------
  // serve while hard reset
  always_comb begin
    next_state = state;
    if (!por_n_in) begin
      next_state = rcss_pkg::RCSS_ST_POR;
    end else begin
      case (state)
        rcss_pkg::RCSS_ST_POR: begin
          if (!hard_reset_n_in) begin
            next_state = rcss_pkg::RCSS_ST_SERVE;
          end else begin
            next_state = rcss_pkg::RCSS_ST_RUN;
          end
        end
        rcss_pkg::RCSS_ST_RUN: begin
          if (!hard_reset_n_in) begin
            next_state = rcss_pkg::RCSS_ST_SERVE;
          end
        end
        rcss_pkg::RCSS_ST_SERVE: begin
          if (hard_reset_n_in) begin
            next_state = rcss_pkg::RCSS_ST_RUN;
          end
        end
        default: begin
          next_state = rcss_pkg::RCSS_ST_POR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state <= rcss_pkg::RCSS_ST_POR;
    end else begin
      state <= next_state;
    end
  end

  assign entering_serve = (next_state == rcss_pkg::RCSS_ST_SERVE) &&
                          (state != rcss_pkg::RCSS_ST_SERVE);

  // ----------------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------------
  // flash enable switch
  assign next_src = pick_src(config_dip_switch_in, force_en,
                             flash_blank_in);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      src <= rcss_pkg::RCSS_SRC_SAFE;
    end else if (entering_serve) begin
      src <= next_src;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cfg_src_out <= rcss_pkg::RCSS_SRC_SAFE;
    end else if (entering_serve) begin
      cfg_src_out <= next_src;
    end
  end

  assign board_src = (src == rcss_pkg::RCSS_SRC_SAFE) ||
                     (src == rcss_pkg::RCSS_SRC_FORCE);

  // ----------------------------------------------------------------------
  // configuration read counting
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= cfg_rd_in;
    end
  end

  assign rd_rise = cfg_rd_in && !rd_q &&
                   (state == rcss_pkg::RCSS_ST_SERVE);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rd_count <= '0;
    end else if (entering_serve || clr_count) begin
      rd_count <= '0;
    end else if (rd_rise && rd_count != rcss_pkg::CNT_W'(
                 rcss_pkg::CFG_WORDS)) begin
      rd_count <= rd_count + rcss_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      idx_hold <= '0;
    end else if (rd_rise) begin
      idx_hold <= rd_count;
    end
  end

  assign read_idx = rd_rise ? rd_count : idx_hold;

  // ----------------------------------------------------------------------
  // word block control
  // ----------------------------------------------------------------------
  // enable only on reads
  assign lnk.word_en = cfg_rd_in && board_src &&
                       (state == rcss_pkg::RCSS_ST_SERVE);
  assign lnk.word_idx = read_idx;
  assign lnk.insert_hi = (src == rcss_pkg::RCSS_SRC_SAFE);
  assign lnk.word_base = (src == rcss_pkg::RCSS_SRC_FORCE) ?
                         force_word : safe_word;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pll_mode_lines_out <= '0;
      pll_mode_oe_out <= 1'b0;
    end else begin
      pll_mode_lines_out <= lnk.mode_lo;
      pll_mode_oe_out <= lnk.mode_oe;
    end
  end

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  assign apb_setup = psel_in && penable_in && !pready_out;
  assign apb_wr = apb_setup && pwrite_in;
  assign apb_rd = apb_setup && !pwrite_in;
  assign addr8 = paddr_in[7:0];
  assign addr_hit = (ADDR_W == 8 || paddr_in >> 8 == '0) &&
                    addr8 <= rcss_pkg::OFF_READ_COUNT &&
                    addr8[1:0] == 2'h0;
  assign clr_count = apb_wr && addr_hit && addr8 == rcss_pkg::OFF_CTRL &&
                     pstrb_in[0] && pwdata_in[rcss_pkg::CTRL_CLR_COUNT_BIT];

  always_comb begin
    status_word = '0;
    status_word[rcss_pkg::STAT_SRC_LSB +: 4] = src;
    status_word[rcss_pkg::STAT_STATE_LSB +: 3] = state;
    status_word[rcss_pkg::STAT_WIDTH_BAD_BIT] =
      (src == rcss_pkg::RCSS_SRC_HOST) && !bus_narrow_in;
    status_word[rcss_pkg::STAT_SW_LSB +: rcss_pkg::SW_W] =
      config_dip_switch_in;
    status_word[rcss_pkg::STAT_MODE_LO_LSB +: rcss_pkg::MODE_W] =
      lnk.mode_lo;
    status_word[rcss_pkg::STAT_MODE_HI_LSB +: rcss_pkg::MODE_W] =
      lnk.mode_hi;
    status_word[rcss_pkg::STAT_BLANK_BIT] = flash_blank_in;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= apb_setup;
      pslverr_out <= apb_setup && !addr_hit;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      prdata_out <= '0;
    end else if (apb_rd && addr_hit) begin
      if (addr8 == rcss_pkg::OFF_CTRL) begin
        prdata_out <= {31'h0, force_en};
      end else if (addr8 == rcss_pkg::OFF_STATUS) begin
        prdata_out <= status_word;
      end else if (addr8 == rcss_pkg::OFF_SAFE_WORD) begin
        prdata_out <= safe_word;
      end else if (addr8 == rcss_pkg::OFF_FORCE_WORD) begin
        prdata_out <= force_word;
      end else begin
        prdata_out <= {28'h0, rd_count};
      end
    end else if (apb_setup) begin
      prdata_out <= '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      force_en <= rcss_pkg::CTRL_RST[rcss_pkg::CTRL_FORCE_BIT];
    end else if (apb_wr && addr_hit && addr8 == rcss_pkg::OFF_CTRL &&
                 pstrb_in[0]) begin
      force_en <= pwdata_in[rcss_pkg::CTRL_FORCE_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      safe_word <= rcss_pkg::SAFE_WORD_RST;
    end else if (apb_wr && addr_hit &&
                 addr8 == rcss_pkg::OFF_SAFE_WORD) begin
      safe_word <= merge(safe_word, pwdata_in, pstrb_in);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      force_word <= rcss_pkg::FORCE_WORD_RST;
    end else if (apb_wr && addr_hit &&
                 addr8 == rcss_pkg::OFF_FORCE_WORD) begin
      force_word <= merge(force_word, pwdata_in, pstrb_in);
    end
  end

endmodule

// file: test/rcss_top_asserts.sv
// assertion checker for the reset configuration source selector
`timescale 1ns/1ps
module rcss_top_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic por_n_in,
  input wire logic hard_reset_n_in,
  input wire logic [rcss_pkg::SW_W-1:0] config_dip_switch_in,
  input wire logic flash_blank_in,
  input wire logic bus_narrow_in,
  input wire logic cfg_rd_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [rcss_pkg::MODE_W-1:0] pll_mode_lines_out,
  input wire logic pll_mode_oe_out,
  input wire logic [3:0] cfg_src_out,
  input wire logic [rcss_pkg::WORD_W-1:0] data_out,
  input wire logic data_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_mode_oe_on:
  assert property (!por_n_in ##1 !por_n_in |=> pll_mode_oe_out)
    else $error("mode lines not driven in power-on reset");
  a_mode_lines_sw:
  assert property (!por_n_in ##1 (!por_n_in
    && $stable(config_dip_switch_in)) |=>
    pll_mode_lines_out == $past(config_dip_switch_in[2:0]))
    else $error("mode lines differ from switches");
  a_mode_frozen:
  assert property (por_n_in [*3] |=>
    $stable(pll_mode_lines_out) && !pll_mode_oe_out)
    else $error("mode lines moved after power-on");
  a_src_host:
  assert property ($fell(hard_reset_n_in) && por_n_in
    && !config_dip_switch_in[7] |=> !cfg_src_out[0] && !cfg_src_out[1])
    else $error("host selection not taken");
  a_src_safe:
  assert property ($fell(hard_reset_n_in) && por_n_in
    && config_dip_switch_in[7] && !config_dip_switch_in[6] |=>
    !cfg_src_out[1] && !cfg_src_out[2])
    else $error("safe selection not taken");
  a_drive_window:
  assert property (data_oe_out |-> $past(cfg_rd_in)
    && !$past(hard_reset_n_in))
    else $error("word driven outside configuration read");
  a_drive_source:
  assert property (data_oe_out |-> cfg_src_out[0] || cfg_src_out[3])
    else $error("word driven for a non-board source");
  a_apb_wait:
  assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("register access not answered");
  a_apb_error:
  assert property (pready_out |-> pslverr_out == ($past(paddr_in) > 'h10
    || $past(paddr_in[1:0]) != 2'h0))
    else $error("wrong error response");
endmodule

bind rcss_top rcss_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk_in,
  .nrst_in, .por_n_in, .hard_reset_n_in, .config_dip_switch_in,
  .flash_blank_in, .bus_narrow_in, .cfg_rd_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out,
  .pslverr_out, .pll_mode_lines_out, .pll_mode_oe_out, .cfg_src_out,
  .data_out, .data_oe_out);

// file: test/rcss_proc_model.sv
// processor model driving the resets and reading configuration words
`timescale 1ns/1ps
module rcss_proc_model (
  input wire logic clk_in,
  input wire logic [31:0] data_in,
  input wire logic data_oe_in,
  output logic por_n_out,
  output logic hard_reset_n_out,
  output logic cfg_rd_out
);
  logic [31:0] bus;
  logic [31:0] last = 32'h0;
  logic [31:0] word [8];
  int n_drv = 0;
  initial begin
    por_n_out = 1'b1;
    hard_reset_n_out = 1'b1;
    cfg_rd_out = 1'b0;
  end
  // released bus shows the inverse of the last driven value
  assign bus = data_oe_in ? data_in : ~last;
  always @(posedge clk_in) begin
    if (data_oe_in) begin
      last <= data_in;
      n_drv++;
    end
  end
  task automatic power_on(input int n);
    @(posedge clk_in);
    por_n_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    por_n_out <= 1'b1;
  endtask
  task automatic hard_reset();
    @(posedge clk_in);
    hard_reset_n_out <= 1'b0;
    n_drv = 0;
    repeat (2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      cfg_rd_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      word[i] = bus;
      cfg_rd_out <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
    hard_reset_n_out <= 1'b1;
  endtask
endmodule

// file: test/test_reset_config_source_select.sv
// self-checking bench for the reset configuration source selector
`timescale 1ns/1ps
module test_reset_config_source_select;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] sw = 8'h00;
  logic blank = 1'b0;
  logic narrow = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, data, rd;
  logic pready, pslverr, por_n, hrst_n, cfg_rd, mode_oe, data_oe, err;
  logic [2:0] mode;
  logic [3:0] src;
  logic [7:0] c;
  logic [7:0] rows [5] = '{8'h81, 8'he1, 8'hc2, 8'h18, 8'h44};
  int n_errors = 0;
  int n_tests = 0;
  always #25 clk_in = ~clk_in;
  rcss_top uut (.clk_in(clk_in), .nrst_in(nrst_in), .por_n_in(por_n),
    .hard_reset_n_in(hrst_n), .config_dip_switch_in(sw),
    .flash_blank_in(blank), .bus_narrow_in(narrow), .cfg_rd_in(cfg_rd),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .pll_mode_lines_out(mode), .pll_mode_oe_out(mode_oe),
    .cfg_src_out(src), .data_out(data), .data_oe_out(data_oe));
  rcss_proc_model u_proc (.clk_in(clk_in), .data_in(data),
    .data_oe_in(data_oe), .por_n_out(por_n), .hard_reset_n_out(hrst_n),
    .cfg_rd_out(cfg_rd));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic summarize();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    chk(src, 32'h1);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      chk(rd, (k == 1) ? 32'h0000_0021 : 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h0a, 32'h1);
    chk(err, 1'b1);
    $display("registers done");
    sw <= 8'h9d;
    u_proc.power_on(6);
    chk({mode_oe, mode}, 4'hd);
    sw <= 8'h92;
    repeat (4) @(posedge clk_in);
    chk({mode_oe, mode}, 4'h5);
    apb(1'b0, rcss_pkg::OFF_STATUS, 32'h0);
    chk({rd[22:20], rd[18:16], rd[15:8]}, 14'h1d92);
    $display("power-on done");
    apb(1'b1, rcss_pkg::OFF_SAFE_WORD, 32'ha5a5_5a5a);
    apb(1'b1, rcss_pkg::OFF_FORCE_WORD, 32'h1234_5678);
    foreach (rows[i]) begin
      c = rows[i];
      sw <= {c[7:6], 6'h12};
      blank <= c[5];
      apb(1'b1, rcss_pkg::OFF_CTRL, {30'h0, 1'b1, c[4]});
      u_proc.hard_reset();
      chk(src, c[3:0]);
      if (c[0] | c[3]) begin
        chk(u_proc.word[0], c[3] ? 32'h1234_5678 : 32'ha5a5_5a5b);
        for (int k = 1; k < 8; k++)
          chk(u_proc.word[k], 32'h0);
      end else begin
        chk(u_proc.n_drv, 0);
      end
      apb(1'b0, rcss_pkg::OFF_READ_COUNT, 32'h0);
      chk(rd, 32'h8);
      apb(1'b0, rcss_pkg::OFF_STATUS, 32'h0);
      chk({rd[24], rd[7], rd[3:0]}, {c[5], c[2], c[3:0]});
      $display("source case %0d done", i);
    end
    narrow <= 1'b1;
    apb(1'b0, rcss_pkg::OFF_STATUS, 32'h0);
    chk(rd[7], 1'b0);
    $display("bus width done");
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    summarize();
  end
endmodule
